/* File: src/ssg_pkg.sv */
// Package of constants for the sensor's two-wire slave guard.
// Assumes a 200 MHz reference clock; all counts derive from it.
package ssg_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  // Bus lock-up timeout window, in milliseconds.
  localparam int unsigned TIMEOUT_MIN_MS  = 15;
  localparam int unsigned TIMEOUT_MAX_MS  = 45;
  // Chosen point inside the window, 25 ms, in cycles.
  localparam int unsigned TIMEOUT_USE_MS  = 25;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_USE_MS * 1000 * CLK_MHZ;
  // Power-up readiness limit, 1 ms, in cycles.
  localparam int unsigned POR_READY_MS    = 1;
  localparam int unsigned POR_READY_CYC   = POR_READY_MS * 1000 * CLK_MHZ;
  // Address select levels on the three-level pin.
  localparam logic [1:0]  ASEL_FLOAT      = 2'h0;
  localparam logic [1:0]  ASEL_GND        = 2'h1;
  localparam logic [1:0]  ASEL_VDD        = 2'h2;
  localparam logic [6:0]  ADDR_FLOAT      = 7'h48;
  localparam logic [6:0]  ADDR_GND        = 7'h49;
  localparam logic [6:0]  ADDR_VDD        = 7'h4A;
  // Implemented pointer values.
  localparam logic [7:0]  PTR_TEMP        = 8'h00;
  localparam logic [7:0]  PTR_MAX         = 8'h07;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [15:0] TEMP_RESET      = 16'h0000;

  // Maps the address-select level onto the slave address.
  function automatic logic [6:0] ssg_addr(input logic [1:0] sel);
    ssg_addr = (sel == ASEL_GND) ? ADDR_GND : (sel == ASEL_VDD) ? ADDR_VDD : ADDR_FLOAT;
  endfunction

  // Tells whether a pointer value selects an implemented register.
  function automatic logic ssg_ptr_ok(input logic [7:0] p);
    ssg_ptr_ok = (p <= PTR_MAX);
  endfunction
endpackage

/* File: src/ssg_line_if.sv */
// Interface carrying synchronised line levels and their edges.
// Assumes both sides run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface ssg_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic lockup;
  modport src (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen, lockup);
  modport dst (input scl, sda, scl_rise, scl_fall, start_seen, stop_seen, lockup);
endinterface
`default_nettype wire

/* File: src/ssg_line_watch.sv */
// Line watcher: synchronises both bus lines, finds edges and bus
// conditions, and times how long either line stays low.
// Assumes raw pin levels arrive asynchronously to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ssg_line_watch
  import ssg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  ssg_line_if.src   lines
);
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_q;
  logic        sda_q;
  logic [31:0] scl_low_cnt;
  logic [31:0] sda_low_cnt;
  logic [1:0]  next_scl_sync;
  logic [1:0]  next_sda_sync;
  logic [31:0] next_scl_low_cnt;
  logic [31:0] next_sda_low_cnt;

  // Saturating count of the cycles one synchronised line has stayed low.
  function automatic logic [31:0] low_time(input logic level, input logic [31:0] cnt);
    if (level) begin
      low_time = 32'h0000_0000;
    end else if (cnt == TIMEOUT_CYCLES) begin
      low_time = cnt;
    end else begin
      low_time = cnt + 32'h0000_0001;
    end
  endfunction

  // Next values: two-stage synchronisers and one low-time counter per line,
  // so that only a line that is itself held low can time out.
  always_comb begin
    next_scl_sync    = {scl_sync[0], scl_in};
    next_sda_sync    = {sda_sync[0], sda_in};
    next_scl_low_cnt = low_time(scl_sync[1], scl_low_cnt);
    next_sda_low_cnt = low_time(sda_sync[1], sda_low_cnt);
  end

  // Registers of the watcher.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      scl_low_cnt <= 32'h0000_0000;
      sda_low_cnt <= 32'h0000_0000;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
      scl_low_cnt <= next_scl_low_cnt;
      sda_low_cnt <= next_sda_low_cnt;
    end
  end

  // Edges and conditions seen on the synchronised levels.
  assign lines.scl        = scl_sync[1];
  assign lines.sda        = sda_sync[1];
  assign lines.scl_rise   = scl_sync[1] & ~scl_q;
  assign lines.scl_fall   = ~scl_sync[1] & scl_q;
  assign lines.start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign lines.stop_seen  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  // One pulse per lock-up: a line that crosses the limit while the other
  // has already timed out does not fire a second reset.
  assign lines.lockup     = ((scl_low_cnt == TIMEOUT_CYCLES - 1) &&
                             (sda_low_cnt != TIMEOUT_CYCLES)) ||
                            ((sda_low_cnt == TIMEOUT_CYCLES - 1) &&
                             (scl_low_cnt != TIMEOUT_CYCLES));
endmodule
`default_nettype wire

/* File: src/ssg_slave.sv */
// Two-wire slave front end of the temperature sensor with lock-up guard.
// Assumes external pull-ups on both lines and a host clocking the bus.
//
// Overview of operation
// - Either line held low past the 15 to 45 ms timeout resets the serial state machine.
// - On that timeout the data line is released and any transfer is abandoned.
// - A read of the result takes each byte from the last completed conversion at the moment that byte starts.
// - The serial interface answers within 1 ms after power-on reset ends.
// - A valid result appears no later than one conversion after the interface is ready.
// - A written pointer that selects no register is answered with a not-acknowledge.
// - An invalid pointer is discarded and the stored pointer kept.
// - The slave answers only its 7-bit address chosen by the select pin.
// - The clock line is never driven and never stretched; data is open-drain.
`timescale 1ns/1ps
`default_nettype none
module ssg_slave
  import ssg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned READY_CYCLES   = POR_READY_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        serial_clock_line_in,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  output logic             serial_clock_line_oe,
  input  wire logic [1:0]  addr_sel,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  output logic             bus_ready,
  output logic             result_valid,
  output logic [7:0]       pointer,
  output logic             lockup_reset
);
  typedef enum logic [2:0] {
    SSG_IDLE = 3'b000,
    SSG_ADDR = 3'b001,
    SSG_AACK = 3'b010,
    SSG_WPTR = 3'b011,
    SSG_PACK = 3'b100,
    SSG_RD   = 3'b101,
    SSG_RACK = 3'b110
  } ssg_state_e;

  ssg_line_if lines ();

  ssg_line_watch #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_watch (
    .ref_clk (ref_clk),
    .rst     (rst),
    .scl_in  (serial_clock_line_in),
    .sda_in  (serial_data_line_in),
    .lines   (lines)
  );

  ssg_state_e  state;
  ssg_state_e  next_state;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic        rd_hi;
  logic        next_rd_hi;
  logic        drive_low;
  logic        next_drive_low;
  logic [7:0]  next_pointer;
  logic [15:0] result;
  logic [15:0] next_result;
  logic        next_result_valid;
  logic [31:0] ready_cnt;
  logic [31:0] next_ready_cnt;
  logic [6:0]  my_addr;
  logic [6:0]  next_my_addr;
  logic [1:0]  asel_meta;
  logic [1:0]  asel_sync;
  logic [1:0]  next_asel_meta;
  logic [1:0]  next_asel_sync;

  // Power-up readiness timer; the select pin passes two flip-flops and the
  // address follows it until the bus turns ready, then stays frozen.
  always_comb begin
    next_ready_cnt = ready_cnt;
    next_my_addr   = my_addr;
    next_asel_meta = addr_sel;
    next_asel_sync = asel_meta;
    if (ready_cnt != READY_CYCLES) begin
      next_ready_cnt = ready_cnt + 32'h0000_0001;
    end
    if (!bus_ready) begin
      next_my_addr = ssg_addr(asel_sync);
    end
  end

  // Result holding: updated only by a completed conversion.
  always_comb begin
    next_result       = result;
    next_result_valid = result_valid;
    if (conv_done && bus_ready) begin
      next_result       = conv_result;
      next_result_valid = 1'b1;
    end
  end

  // Serial state machine, sampling on clock rises, changing on falls.
  always_comb begin
    next_state     = state;
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_rd_hi     = rd_hi;
    next_drive_low = drive_low;
    next_pointer   = pointer;
    if (lines.lockup) begin
      next_state     = SSG_IDLE;
      next_drive_low = 1'b0;
      next_bit_cnt   = 4'h0;
    end else if (!bus_ready || lines.stop_seen) begin
      next_state     = SSG_IDLE;
      next_drive_low = 1'b0;
    end else if (lines.start_seen) begin
      next_state     = SSG_ADDR;
      next_bit_cnt   = 4'h0;
      next_drive_low = 1'b0;
    end else begin
      unique case (state)
        SSG_IDLE: begin
        end
        SSG_ADDR, SSG_WPTR: begin
          if (lines.scl_rise) begin
            next_shift   = {shift[6:0], lines.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (lines.scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            if (state == SSG_ADDR) begin
              if (shift[7:1] == my_addr) begin
                next_state     = SSG_AACK;
                next_drive_low = 1'b1;
                next_rd_hi     = 1'b1;
              end else begin
                next_state = SSG_IDLE;
              end
            end else if (ssg_ptr_ok(shift)) begin
              next_pointer   = shift;
              next_state     = SSG_PACK;
              next_drive_low = 1'b1;
            end else begin
              next_state = SSG_PACK;
            end
          end
        end
        SSG_AACK, SSG_PACK, SSG_RACK: begin
          if (lines.scl_rise && state == SSG_RACK && lines.sda) begin
            next_state = SSG_IDLE;
          end else if (lines.scl_fall) begin
            next_drive_low = 1'b0;
            if (state == SSG_PACK) begin
              next_state = SSG_IDLE;
            end else if (state == SSG_AACK && !shift[0]) begin
              next_state = SSG_WPTR;
            end else begin
              next_state     = SSG_RD;
              next_shift     = (pointer == PTR_TEMP) ?
                               (rd_hi ? result[15:8] : result[7:0]) : 8'h00;
              next_rd_hi     = ~rd_hi;
              next_drive_low = ~next_shift[7];
              next_bit_cnt   = 4'h1;
            end
          end
        end
        SSG_RD: begin
          if (lines.scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_state     = SSG_RACK;
              next_drive_low = 1'b0;
            end else begin
              next_shift     = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
              next_bit_cnt   = bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          next_state = SSG_IDLE;
        end
      endcase
    end
  end

  // Registers of the slave.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state        <= SSG_IDLE;
      shift        <= 8'h00;
      bit_cnt      <= 4'h0;
      rd_hi        <= 1'b1;
      drive_low    <= 1'b0;
      pointer      <= PTR_RESET;
      result       <= TEMP_RESET;
      result_valid <= 1'b0;
      ready_cnt    <= 32'h0000_0000;
      my_addr      <= ADDR_FLOAT;
      asel_meta    <= ASEL_FLOAT;
      asel_sync    <= ASEL_FLOAT;
      lockup_reset <= 1'b0;
    end else begin
      state        <= next_state;
      shift        <= next_shift;
      bit_cnt      <= next_bit_cnt;
      rd_hi        <= next_rd_hi;
      drive_low    <= next_drive_low;
      pointer      <= next_pointer;
      result       <= next_result;
      result_valid <= next_result_valid;
      ready_cnt    <= next_ready_cnt;
      my_addr      <= next_my_addr;
      asel_meta    <= next_asel_meta;
      asel_sync    <= next_asel_sync;
      lockup_reset <= lines.lockup;
    end
  end

  // Open-drain data pin, clock pin never driven.
  assign bus_ready            = (ready_cnt == READY_CYCLES);
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe  = drive_low;
  assign serial_clock_line_oe = 1'b0;
endmodule
`default_nettype wire

/* File: test/ssg_slave_checker.sv */
// Checker for the two-wire slave guard, bound to the slave's ports.
// Assumes one ref_clk domain with an asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module ssg_slave_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 200,
  parameter int unsigned READY_CYCLES   = 20
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       serial_clock_line_in,
  input wire logic       serial_data_line_in,
  input wire logic       serial_data_line_oe,
  input wire logic       serial_clock_line_oe,
  input wire logic       conv_done,
  input wire logic       bus_ready,
  input wire logic       result_valid,
  input wire logic [7:0] pointer,
  input wire logic       lockup_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int unsigned scl_lo, sda_lo, rdy_cnt;
  int unsigned next_scl_lo, next_sda_lo, next_rdy_cnt;
  // Low time of each raw line, and time since reset saturating at 1000.
  always_comb begin
    next_scl_lo = serial_clock_line_in ? 0 : scl_lo + 1;
    next_sda_lo = serial_data_line_in ? 0 : sda_lo + 1;
    next_rdy_cnt = (rdy_cnt < 1000) ? rdy_cnt + 1 : rdy_cnt;
  end
  // Registers the counters.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_lo <= 0;
      sda_lo <= 0;
      rdy_cnt <= 0;
    end else begin
      scl_lo <= next_scl_lo;
      sda_lo <= next_sda_lo;
      rdy_cnt <= next_rdy_cnt;
    end
  end
  clk_undriven_a: assert property (!serial_clock_line_oe)
    else $error("clock line driven");
  lock_release_a: assert property (lockup_reset |-> ##[0:1] !serial_data_line_oe)
    else $error("data line held after timeout");
  lock_keeps_ptr_a: assert property (lockup_reset |-> $stable(pointer))
    else $error("pointer changed by timeout");
  lock_cause_a: assert property (lockup_reset |->
    (scl_lo >= TIMEOUT_CYCLES - 1 || sda_lo >= TIMEOUT_CYCLES - 1))
    else $error("timeout fired early");
  lock_pulse_a: assert property (lockup_reset |=> !lockup_reset)
    else $error("timeout pulse too long");
  ready_late_a: assert property (rdy_cnt >= READY_CYCLES + 3 |-> bus_ready)
    else $error("bus not ready in time");
  valid_order_a: assert property (!bus_ready |-> !result_valid)
    else $error("result valid before ready");
  valid_set_a: assert property (conv_done && bus_ready |=> result_valid)
    else $error("result valid not set");
  ptr_legal_a: assert property ($changed(pointer) |-> pointer <= 8'h07)
    else $error("illegal pointer stored");
endmodule
bind ssg_slave ssg_slave_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .READY_CYCLES(READY_CYCLES)) u_chk (.ref_clk, .rst, .serial_clock_line_in,
  .serial_data_line_in, .serial_data_line_oe, .serial_clock_line_oe, .conv_done,
  .bus_ready, .result_valid, .pointer, .lockup_reset);
`default_nettype wire

/* File: test/ssg_host_model.sv */
// Bus host model: drives both lines open-drain, 64 ns bit period.
// Assumes pull-ups on both wires in the bench.
`timescale 1ns/1ps
`default_nettype none
module ssg_host_model (
  output logic     scl_oe,
  output logic     sda_oe,
  input wire logic sda
);
  // Quarter bit; every clock low phase inside a task stays far below the bench timeout.
  localparam int Q = 16;
  // Bus starts idle with both lines released.
  initial begin
    scl_oe = 0;
    sda_oe = 0;
  end
  // One bit: data set while clock is low, sampled while it is high.
  task automatic bit_io(input logic b, output logic r);
    sda_oe = !b;
    #Q scl_oe = 0;
    #Q r = sda;
    #Q scl_oe = 1;
    #Q;
  endtask
  // Start or repeated start: data falls while clock is high.
  task automatic start();
    sda_oe = 0;
    #Q scl_oe = 0;
    #Q sda_oe = 1;
    #Q scl_oe = 1;
    #Q;
  endtask
  // Stop: data rises while clock is high.
  task automatic stop();
    sda_oe = 1;
    #Q scl_oe = 0;
    #Q sda_oe = 0;
    #Q;
  endtask
  // One byte, high bit first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask
endmodule
`default_nettype wire

/* File: test/test_smbus_sensor_slave_guard.sv */
// Bench for the two-wire slave guard with a host model on the bus.
// Assumes the short timeout and ready counts set below.
`timescale 1ns/1ps
`default_nettype none
module test_smbus_sensor_slave_guard;
  import ssg_pkg::*;
  localparam int unsigned TO = 200;
  localparam int unsigned RDY = 20;
  logic        ref_clk, rst, conv_done, h_scl, h_sda, d_out, d_oe, d_scl;
  logic        bus_ready, result_valid, lockup_reset;
  logic [1:0]  addr_sel;
  logic [7:0]  pointer;
  logic [15:0] conv_result, rd;
  int          error_cnt = 0;
  int          num_checks = 0;
  wire logic   scl_w = !(h_scl | d_scl);
  wire logic   sda_w = !h_sda & (d_oe ? d_out : 1'b1);
  ssg_slave #(.TIMEOUT_CYCLES(TO), .READY_CYCLES(RDY)) dut (.ref_clk, .rst,
    .serial_clock_line_in(scl_w), .serial_data_line_in(sda_w),
    .serial_data_line_out(d_out), .serial_data_line_oe(d_oe),
    .serial_clock_line_oe(d_scl), .addr_sel, .conv_done, .conv_result,
    .bus_ready, .result_valid, .pointer, .lockup_reset);
  ssg_host_model host (.scl_oe(h_scl), .sda_oe(h_sda), .sda(sda_w));
  // Reference clock, 5 ns period.
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Compares and counts one value.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Pulses one finished conversion.
  task automatic conv(input logic [15:0] v);
    @(negedge ref_clk);
    conv_done = 1;
    conv_result = v;
    @(negedge ref_clk);
    conv_done = 0;
  endtask
  // Resets with an address select; an early conversion must be ignored.
  task automatic boot(input logic [1:0] sel);
    @(negedge ref_clk);
    rst = 1;
    addr_sel = sel;
    repeat (5) @(negedge ref_clk);
    rst = 0;
    conv(16'h1111);
    chk(bus_ready, 0);
    for (int i = 0; !bus_ready; i++) begin
      if (i > RDY + 10) begin
        error_cnt++;
        tally_and_finish();
      end
      @(negedge ref_clk);
    end
    chk(bus_ready, 1);
    chk(result_valid, 0);
  endtask
  // Pointer write; returns both acknowledge bits.
  task automatic wr_ptr(input logic [7:0] p, output logic [1:0] a);
    logic [7:0] q;
    host.start();
    host.xfer({ADDR_FLOAT, 1'b0}, 1'b1, q, a[1]);
    host.xfer(p, 1'b1, q, a[0]);
    host.stop();
  endtask
  // Two-byte read, high byte first, host ends with a not-acknowledge.
  task automatic rd16(output logic [15:0] v);
    logic a;
    host.start();
    host.xfer({ADDR_FLOAT, 1'b1}, 1'b1, v[15:8], a);
    chk(a, 0);
    host.xfer(8'hFF, 1'b0, v[15:8], a);
    host.xfer(8'hFF, 1'b1, v[7:0], a);
    host.stop();
  endtask
  // Each select level answers its own address and refuses the others.
  task automatic s_addr();
    logic [6:0] tbl [3];
    logic [7:0] q;
    logic       a;
    tbl = '{ADDR_FLOAT, ADDR_GND, ADDR_VDD};
    for (int s = 2; s >= 0; s--) begin
      boot(s[1:0]);
      for (int w = 0; w < 3; w++) begin
        host.start();
        host.xfer({tbl[w], 1'b0}, 1'b1, q, a);
        host.stop();
        chk(a, w != s);
      end
    end
  endtask
  // Top legal pointer taken; pointers past it refused and discarded.
  task automatic s_ptr();
    logic [1:0] a;
    wr_ptr(8'h07, a);
    chk(a, 2'h0);
    chk(pointer, 8'h07);
    wr_ptr(8'h08, a);
    chk(a, 2'h1);
    chk(pointer, 8'h07);
    wr_ptr(8'hFF, a);
    chk(a, 2'h1);
    chk(pointer, 8'h07);
  endtask
  // Reads return the latest finished conversion, valid once converted.
  task automatic s_read();
    logic [1:0] a;
    conv(16'h5A3C);
    @(negedge ref_clk);
    chk(result_valid, 1);
    wr_ptr(8'h00, a);
    rd16(rd);
    chk(rd, 16'h5A3C);
    conv(16'h9876);
    rd16(rd);
    chk(rd, 16'h9876);
  endtask
  // Clock held low mid-read: slave lets go of data, keeps its pointer.
  task automatic s_lock();
    logic [1:0] a;
    logic [7:0] q;
    logic       b;
    int         n;
    wr_ptr(8'h05, a);
    host.start();
    host.xfer({ADDR_FLOAT, 1'b1}, 1'b1, q, b);
    @(negedge ref_clk);
    chk(d_oe, 1);
    chk(d_out, 0);
    chk(d_scl, 0);
    for (n = 0; !lockup_reset && n < TO + 40; n++) @(negedge ref_clk);
    chk(n >= TO - 20 && n < TO + 40, 1);
    @(negedge ref_clk);
    chk(d_oe, 0);
    chk(pointer, 8'h05);
    host.stop();
    wr_ptr(8'h00, a);
    chk(a, 2'h0);
    rd16(rd);
    chk(rd, 16'h9876);
  endtask
  // Main sequence.
  initial begin
    rst = 1;
    conv_done = 0;
    conv_result = 16'h0000;
    addr_sel = 2'h0;
    s_addr();
    s_ptr();
    s_read();
    s_lock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
